// file: rtl/rtsp_map.vh
`ifndef RTSP_MAP_VH
`define RTSP_MAP_VH
// Processor status codes
`define RTSP_ST_CONT 4'h0
`define RTSP_ST_BEGIN 4'h1
`define RTSP_ST_USER 4'h3
`define RTSP_ST_PULSE 4'h4
`define RTSP_ST_BRANCH 4'h5
`define RTSP_ST_EXCRET 4'h7
`define RTSP_ST_MARK1 4'h8
`define RTSP_ST_EXCP 4'hc
`define RTSP_ST_EMU 4'hd
`define RTSP_ST_STOP 4'he
`define RTSP_ST_HALT 4'hf
// Instruction event classes from the core
`define RTSP_EV_NONE 3'h0
`define RTSP_EV_BEGIN 3'h1
`define RTSP_EV_PULSE 3'h2
`define RTSP_EV_WDATA 3'h3
`define RTSP_EV_BRANCH 3'h4
`define RTSP_EV_EXCRET 3'h5
// Branch address length configuration: off, 2, 3 or 4 bytes
`define RTSP_BLEN_OFF 2'h0
`define RTSP_BLEN_2 2'h1
`define RTSP_BLEN_3 2'h2
`define RTSP_BLEN_4 2'h3
// Idle data nibble
`define RTSP_DATA_IDLE 4'h0
`endif

// file: rtl/rtsp_fifo.v
`timescale 1ns/1ps
`include "rtsp_map.vh"
module rtsp_fifo #(
  parameter WIDTH = 34,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire clk, // Clock
  input wire rst_n, // Async reset, active low
  input wire ce, // Clock enable
  input wire inValid, // Write request
  output wire inReady, // Space free
  input wire [WIDTH-1:0] inData, // Write data
  output wire outValid, // Entry held
  input wire outReady, // Read accept
  output reg [WIDTH-1:0] outData // Head entry, registered
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr;
  reg [AW:0] rdPtr;
  wire [AW:0] level = wrPtr - rdPtr;
  wire doWr = ce & inValid & inReady;
  wire doRd = ce & outValid & outReady;
  wire [AW:0] nextRd = doRd ? rdPtr + 1'b1 : rdPtr;
  assign inReady = (level != DEPTH[AW:0]);
  assign outValid = (level != {(AW+1){1'b0}});
  // Storage array, no reset needed
  always @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end
  // Pointers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= {(AW+1){1'b0}};
      rdPtr <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr <= wrPtr + 1'b1;
      end
      rdPtr <= nextRd;
    end
  end
  // Registered head: bypass when writing the slot about to be read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outData <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (doWr && (wrPtr[AW-1:0] == nextRd[AW-1:0])) begin
        outData <= inData;
      end else begin
        outData <= mem[nextRd[AW-1:0]];
      end
    end
  end
endmodule // rtsp_fifo

// file: rtl/rtsp_sync.v
`timescale 1ns/1ps
module rtsp_sync #(
  parameter W = 2
) (
  input wire clk, // Clock
  input wire rst_n, // Async reset, active low
  input wire ce, // Clock enable
  input wire [W-1:0] pinIn, // Asynchronous pin levels
  output reg [W-1:0] level // Filtered level
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  // Three stages; accept once stages two and three agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      level <= {W{1'b0}};
    end else if (ce) begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
      level <= (s2 & ~(s2 ^ s3)) | (level & (s2 ^ s3));
    end
  end
endmodule // rtsp_sync

// file: rtl/rtsp_trace_port.v
//Functional notes
// R1 - Two separate 4-bit outputs: status nibble and data nibble.
// R2 - Status follows pipeline events, not the bus transfer.
// R3 - Two-entry 32-bit FIFO holds captured addresses and operands.
// R4 - Buffered values shift out four bits per cycle, low nibble first.
// R5 - Stall core only while both entries full; release when one frees.
// R6 - Code 0x0 on every later cycle of a multi-cycle instruction.
// R7 - Code 0x1 marks first cycle of ordinary instructions.
// R8 - Code 0x3 after the instruction that entered user mode.
// R9 - Code 0x4 on pulse or data-write; data-write adds marker and operand.
// R10 - Code 0x5 on taken branch; target may follow with marker.
// R11 - Code 0x7 starts a return-from-exception instruction.
// R12 - Markers 0x8-0xB give byte count, one cycle before first data.
// R13 - Code 0xC held through ordinary exception processing.
// R14 - Code 0xD held through emulator-mode entry processing.
// R15 - Code 0xE held while stopped until an interrupt.
// R16 - Code 0xF held while halted until restart or reset.
// R17 - Reserved codes 0x2 and 0x6 are never driven.
// R18 - Both nibbles update every processor cycle.
// R19 - Branch target length configurable as two, three or four bytes.
// R20 - Full buffer with new capture stalls pipeline showing 0x0.
`timescale 1ns/1ps
`include "rtsp_map.vh"
module rtsp_trace_port #(
  parameter DW = 32,
  parameter DEPTH = 2
) (
  input wire clk, // Processor clock, 200 MHz
  input wire rst_n, // Async reset, active low
  input wire ce, // Clock enable
  input wire [2:0] instrEvent, // Instruction start class
  input wire instrCont, // Later cycle of current instruction
  input wire userEntry, // Previous instruction entered user mode
  input wire excpActive, // Ordinary exception processing
  input wire emuActive, // Emulator-mode exception processing
  input wire [DW-1:0] captData, // Operand or branch target
  input wire [1:0] wdataSize, // Operand size 0 byte,1 word,2 long
  input wire [1:0] branchLen, // Branch target byte count setting
  input wire stopPin, // Stopped state level, asynchronous
  input wire haltPin, // Halted state level, asynchronous
  output reg coreStall, // Hold core pipeline
  output reg [3:0] processor_trace_status, // Status nibble
  output reg [3:0] trace_data_nibble // Data nibble
);
  // -------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------
  wire [1:0] pinLevel;
  wire stopped = pinLevel[0];
  wire halted = pinLevel[1];
  rtsp_sync #(.W(2)) uSync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pinIn({haltPin, stopPin}),
    .level(pinLevel)
  );

  // -------------------------------------------------------------
  // Capture decode
  // -------------------------------------------------------------
  // Byte count minus one for a capture, 2 bits
  function [1:0] byteCountM1;
    input [2:0] ev;
    input [1:0] wsz;
    input [1:0] blen;
    begin
      if (ev == `RTSP_EV_WDATA) begin
        byteCountM1 = (wsz == 2'h0) ? 2'h0 : (wsz == 2'h1) ? 2'h1 : 2'h3;
      end else begin
        byteCountM1 = blen;
      end
    end
  endfunction

  wire isWdata = (instrEvent == `RTSP_EV_WDATA);
  wire isBranchCap = (instrEvent == `RTSP_EV_BRANCH) &&
    (branchLen != `RTSP_BLEN_OFF);
  wire wantCapt = isWdata | isBranchCap;
  wire [1:0] capM1 = byteCountM1(instrEvent, wdataSize, branchLen);
  wire fifoInReady;
  wire fifoOutValid;
  wire [DW+1:0] fifoOut;
  // R20 full stall
  // R5 stall release
  wire blockCapt = wantCapt & ~fifoInReady & ~halted & ~stopped;
  wire pushCapt = wantCapt & fifoInReady & ~halted & ~stopped;

  // -------------------------------------------------------------
  // Output shifter state
  // -------------------------------------------------------------
  localparam SH_IDLE = 2'h0;
  localparam SH_MARK = 2'h1;
  localparam SH_DATA = 2'h2;
  reg [1:0] shState;
  reg [1:0] next_shState;
  reg [DW-1:0] shReg;
  reg [2:0] nibLeft;
  reg [2:0] next_nibLeft;
  reg popFifo;
  // Marker goes out one cycle ahead of the first data nibble
  wire markNow = (shState == SH_IDLE) && fifoOutValid && !halted &&
    !stopped && !emuActive && !excpActive;
  wire [3:0] markCode = `RTSP_ST_MARK1 | {2'h0, fifoOut[DW+1:DW]};

  // R3 two-entry buffer
  rtsp_fifo #(.WIDTH(DW + 2), .DEPTH(DEPTH), .AW(1)) uFifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .inValid(pushCapt),
    .inReady(fifoInReady),
    .inData({capM1, captData}),
    .outValid(fifoOutValid),
    .outReady(popFifo),
    .outData(fifoOut)
  );

  // Shifter sequencing: marker cycle, then data nibbles
  always @* begin
    next_shState = shState;
    next_nibLeft = nibLeft;
    popFifo = 1'b0;
    case (shState)
      SH_IDLE: begin
        if (markNow) begin
          next_shState = SH_MARK;
        end
      end
      SH_MARK: begin
        popFifo = 1'b1;
        next_shState = SH_DATA;
        next_nibLeft = {fifoOut[DW+1:DW], 1'b1};
      end
      SH_DATA: begin
        if (nibLeft == 3'h0) begin
          next_shState = SH_IDLE;
        end else begin
          next_nibLeft = nibLeft - 3'h1;
        end
      end
      default: begin
        next_shState = SH_IDLE;
      end
    endcase
  end

  // R4 low nibble first
  // R18 update every cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shState <= SH_IDLE;
      nibLeft <= 3'h0;
      shReg <= {DW{1'b0}};
      trace_data_nibble <= `RTSP_DATA_IDLE;
    end else if (ce) begin
      shState <= next_shState;
      nibLeft <= next_nibLeft;
      if (shState == SH_MARK) begin
        shReg <= fifoOut[DW-1:0] >> 4;
        trace_data_nibble <= fifoOut[3:0];
      end else if (shState == SH_DATA && nibLeft != 3'h0) begin
        shReg <= shReg >> 4;
        trace_data_nibble <= shReg[3:0];
      end else begin
        trace_data_nibble <= `RTSP_DATA_IDLE;
      end
    end
  end

  // -------------------------------------------------------------
  // Status nibble encoder
  // -------------------------------------------------------------
  reg [3:0] next_status;
  // R2 pipeline-based status
  // R17 no reserved codes
  always @* begin
    next_status = `RTSP_ST_CONT;
    if (halted) begin
      // R16 halted code
      next_status = `RTSP_ST_HALT;
    end else if (stopped) begin
      // R15 stopped code
      next_status = `RTSP_ST_STOP;
    end else if (emuActive) begin
      // R14 emulator entry
      next_status = `RTSP_ST_EMU;
    end else if (excpActive) begin
      // R13 exception hold
      next_status = `RTSP_ST_EXCP;
    end else if (markNow) begin
      // R12 marker before data
      next_status = markCode;
    end else if (blockCapt) begin
      // R20 stall shows continue
      next_status = `RTSP_ST_CONT;
    end else if (instrCont) begin
      // R6 later instruction cycles
      next_status = `RTSP_ST_CONT;
    end else if (userEntry) begin
      // R8 user mode entry
      next_status = `RTSP_ST_USER;
    end else begin
      case (instrEvent)
        // R7 instruction begin
        `RTSP_EV_BEGIN: next_status = `RTSP_ST_BEGIN;
        // R9 pulse and data write
        `RTSP_EV_PULSE: next_status = `RTSP_ST_PULSE;
        `RTSP_EV_WDATA: next_status = `RTSP_ST_PULSE;
        // R10 taken branch
        // R19 branch length setting
        `RTSP_EV_BRANCH: next_status = `RTSP_ST_BRANCH;
        // R11 exception return
        `RTSP_EV_EXCRET: next_status = `RTSP_ST_EXCRET;
        // R6 continuation cycles
        default: next_status = `RTSP_ST_CONT;
      endcase
    end
  end

  // R1 two nibble outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      processor_trace_status <= `RTSP_ST_CONT;
      coreStall <= 1'b0;
    end else if (ce) begin
      processor_trace_status <= next_status;
      // R5 stall while full
      coreStall <= blockCapt;
    end
  end
endmodule // rtsp_trace_port

// file: verif/rtsp_trace_port_chk_sva.sv
`timescale 1ns/1ps
module rtsp_trace_port_chk (
  input wire clk, // Clock
  input wire rst_n, // Reset
  input wire ce, // Clock enable
  input wire instrCont, // Continue
  input wire userEntry, // User entry
  input wire [2:0] instrEvent, // Event
  input wire excpActive, // Exception
  input wire emuActive, // Emulator
  input wire stopPin, // Stop
  input wire haltPin, // Halt
  input wire coreStall, // Stall
  input wire [3:0] processor_trace_status // Status
);
  // Shorthands for status and idle levels
  wire [3:0] st = processor_trace_status;
  wire mk = st[3:2] == 2'b10;
  logic [2:0] pinQuiet;
  // Cycles since either pin was last seen high, saturating
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinQuiet <= 3'h7;
    end else if (stopPin || haltPin) begin
      pinQuiet <= 3'h0;
    end else if (pinQuiet != 3'h7) begin
      pinQuiet <= pinQuiet + 3'h1;
    end
  end
  // Pins settled through the synchroniser and state not frozen
  wire pins = ce && (pinQuiet > 3'h4);
  wire calm = pins && !excpActive && !emuActive && !coreStall &&
    !userEntry && !instrCont;
  wire [2:0] ev = instrEvent;
  // Status nibble checks
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  no_resv_a: assert property (st != 4'h2 && st != 4'h6)
    else $error("reserved code");
  op_begin_a: assert property (calm && ev == 3'h1 |=> mk || st == 4'h1)
    else $error("begin code");
  pulse_op_a: assert property (calm && ev == 3'h2 |=> mk || st == 4'h4)
    else $error("pulse code");
  exc_ret_a: assert property (calm && ev == 3'h5 |=> mk || st == 4'h7)
    else $error("return code");
  exc_hold_a: assert property (pins && excpActive && !emuActive
    |=> st == 4'hc) else $error("exception code");
  emu_hold_a: assert property (pins && emuActive |=> st == 4'hd)
    else $error("emulator code");
  halt_hold_a: assert property ((haltPin && ce) [*5] |=> st == 4'hf)
    else $error("halt code");
  stall_code_a: assert property (coreStall && !$past(excpActive) &&
    !$past(emuActive) |-> mk || st == 4'h0) else $error("stall code");
endmodule // rtsp_trace_port_chk
bind rtsp_trace_port rtsp_trace_port_chk i_rtsp_trace_port_chk (.clk(clk),
  .rst_n(rst_n), .ce(ce), .instrCont(instrCont), .userEntry(userEntry),
  .instrEvent(instrEvent), .excpActive(excpActive),
  .emuActive(emuActive), .stopPin(stopPin), .haltPin(haltPin),
  .coreStall(coreStall), .processor_trace_status(processor_trace_status));

// file: verif/rtsp_trace_sampler.sv
`timescale 1ns/1ps
module rtsp_trace_sampler (
  input wire clk, // Clock out
  input wire rst_n, // Reset
  input wire [3:0] statusNib, // Status
  input wire [3:0] dataNib, // Data
  output logic [31:0] got [0:15], // Words
  output logic [7:0] gotCnt // Count
);
  logic [3:0] left;
  logic [4:0] pos;
  logic [31:0] acc;
  wire [31:0] nib = {28'h0, dataNib} << pos;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left <= 4'h0;
      gotCnt <= 8'h0;
    end else begin
      if (left != 4'h0) begin
        acc <= acc | nib;
        pos <= pos + 5'h4;
        left <= left - 4'h1;
      end
      if (left == 4'h1) begin
        got[gotCnt[3:0]] <= acc | nib;
        gotCnt <= gotCnt + 8'h1;
      end
      if (statusNib[3:2] == 2'b10) begin
        left <= {1'b0, statusNib[1:0], 1'b0} + 4'h2;
        pos <= 5'h0;
        acc <= 32'h0;
      end
    end
  end
endmodule // rtsp_trace_sampler

// file: verif/rtsp_trace_port_tb.sv
`timescale 1ns/1ps
module rtsp_trace_port_tb;
  logic clk, rst_n, ce, cont, user, excp, emu, stop, halt, stall;
  logic [2:0] ev;
  logic [1:0] wsz, blen;
  logic [31:0] data;
  logic [3:0] st, dn;
  logic [31:0] got [0:15];
  logic [7:0] cnt, n;
  int numErrors, compares, cyc, i, k;
  // Design and trace sampler
  rtsp_trace_port i_rtsp_trace_port (.clk(clk), .rst_n(rst_n), .ce(ce),
    .instrEvent(ev), .instrCont(cont), .userEntry(user), .excpActive(excp),
    .emuActive(emu), .captData(data), .wdataSize(wsz), .branchLen(blen),
    .stopPin(stop), .haltPin(halt), .coreStall(stall),
    .processor_trace_status(st), .trace_data_nibble(dn));
  rtsp_trace_sampler i_rtsp_trace_sampler (.clk(clk), .rst_n(rst_n),
    .statusNib(st), .dataNib(dn), .got(got), .gotCnt(cnt));
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Cycle ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      numErrors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      numErrors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (numErrors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One cycle of event and levels, then the status
  task automatic drive(input logic [2:0] e, input logic [3:0] lv,
      input logic [3:0] exp);
    {user, excp, emu, cont} = lv;
    ev = e;
    @(negedge clk);
    check(st, exp);
  endtask
  // Plain codes and held modes
  task automatic t_codes();
    drive(3'h1, 4'h0, 4'h1);
    drive(3'h2, 4'h0, 4'h4);
    drive(3'h4, 4'h0, 4'h5);
    drive(3'h5, 4'h0, 4'h7);
    ce = 1'b0;
    drive(3'h1, 4'h0, 4'h7);
    ce = 1'b1;
    drive(3'h0, 4'h1, 4'h0);
    drive(3'h0, 4'h8, 4'h3);
    drive(3'h0, 4'h4, 4'hc);
    drive(3'h0, 4'h4, 4'hc);
    drive(3'h0, 4'h6, 4'hd);
    drive(3'h0, 4'h0, 4'h0);
  endtask
  // Every capture length, rebuilt by the sampler
  task automatic t_capture();
    for (i = 0; i < 6; i++) begin
      n = cnt;
      data = 32'hfedcba98 - i;
      blen = (i < 3) ? i[1:0] + 2'h1 : 2'h0;
      wsz = i[1:0] + 2'h1;
      drive((i < 3) ? 3'h4 : 3'h3, 4'h0, (i < 3) ? 4'h5 : 4'h4);
      ev = 3'h0;
      for (k = 0; k < 40 && cnt == n; k++)
        @(negedge clk);
      k = (i < 3) ? 16 + 8 * i : 8 << (i - 3);
      check(got[n[3:0]], data & (32'hffffffff >> (32 - k)));
    end
  endtask
  // Long writes every cycle until four are accepted, expecting a refusal
  task automatic t_stall();
    n = cnt;
    i = 0;
    k = 0;
    wsz = 2'h2;
    ev = 3'h3;
    while (i < 4 && k < 50) begin
      data = 32'h13572468 + i;
      @(negedge clk);
      if (stall === 1'b1)
        k++;
      else
        i++;
    end
    ev = 3'h0;
    check(k != 0, 1'b1);
    for (k = 0; k < 99 && cnt != n + 4; k++)
      @(negedge clk);
    for (i = 0; i < 4; i++)
      check(got[n[3:0] + i], 32'h13572468 + i);
  endtask
  // Stop then halt levels
  task automatic t_pins();
    stop = 1'b1;
    repeat (6) @(negedge clk);
    check(st, 4'he);
    halt = 1'b1;
    repeat (6) @(negedge clk);
    check(st, 4'hf);
  endtask
  // Reset then scenarios
  initial begin
    {rst_n, cont, user, excp, emu, stop, halt, ev, wsz, blen} = '0;
    data = 32'h0;
    ce = 1'b1;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_codes();
    t_capture();
    t_stall();
    t_pins();
    report_and_stop();
  end
endmodule // rtsp_trace_port_tb
